//--- fsp_core_model.sv
/*
  Processor core model: an AXI4-Lite master that issues register and table
  accesses and holds off writes, but not reads, while the sequencer stalls it.
  Assumes one clock shared with the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module fsp_core_model
  import fsp_pkg::*;
(
  // Clock and stall.
  input  wire logic        aclk,
  input  wire logic        core_stall,
  // Write address, data and response.
  output logic [7:0]       m_axi_awaddr,
  output logic             m_axi_awvalid,
  input  wire logic        m_axi_awready,
  output logic [31:0]      m_axi_wdata,
  output logic [3:0]       m_axi_wstrb,
  output logic             m_axi_wvalid,
  input  wire logic        m_axi_wready,
  input  wire logic [1:0]  m_axi_bresp,
  input  wire logic        m_axi_bvalid,
  output logic             m_axi_bready,
  // Read.
  output logic [7:0]       m_axi_araddr,
  output logic             m_axi_arvalid,
  input  wire logic        m_axi_arready,
  input  wire logic [31:0] m_axi_rdata,
  input  wire logic [1:0]  m_axi_rresp,
  input  wire logic        m_axi_rvalid,
  output logic             m_axi_rready
);
  initial
  begin
    m_axi_awaddr = 8'h00;
    m_axi_awvalid = 1'b0;
    m_axi_wdata = 32'h0;
    m_axi_wstrb = 4'h0;
    m_axi_wvalid = 1'b0;
    m_axi_bready = 1'b0;
    m_axi_araddr = 8'h00;
    m_axi_arvalid = 1'b0;
    m_axi_rready = 1'b0;
  end

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    while (core_stall) @(posedge aclk);
    @(posedge aclk);
    m_axi_awaddr <= a;
    m_axi_awvalid <= 1'b1;
    m_axi_wdata <= d;
    m_axi_wstrb <= 4'hf;
    m_axi_wvalid <= 1'b1;
    m_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (m_axi_awvalid && m_axi_awready) m_axi_awvalid <= 1'b0;
      if (m_axi_wvalid && m_axi_wready) m_axi_wvalid <= 1'b0;
    end
    while (!m_axi_bvalid);
    r = m_axi_bresp;
    m_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    m_axi_araddr <= a;
    m_axi_arvalid <= 1'b1;
    m_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (m_axi_arvalid && m_axi_arready) m_axi_arvalid <= 1'b0;
    end
    while (!m_axi_rvalid);
    d = m_axi_rdata;
    r = m_axi_rresp;
    m_axi_rready <= 1'b0;
  endtask

  // The model takes no interrupts, so nothing can split the key writes.
  task automatic unlock_start(input logic [7:0] ctrl);
    logic [1:0] r;
    axi_write(FSP_OFF_CTRL, {24'h0, ctrl}, r);
    axi_write(FSP_OFF_KEY, {24'h0, FSP_KEY1}, r);
    axi_write(FSP_OFF_KEY, {24'h0, FSP_KEY2}, r);
    axi_write(FSP_OFF_CTRL, {24'h0, ctrl | 8'h02}, r);
  endtask
endmodule
`default_nettype wire

//--- fsp_flash_array.sv
/*
  Flash array store: word organised, row erase to 16'hffff, 8-byte program.
  Assumes commands come from the sequencer one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_array
  import fsp_pkg::*;
#(
  parameter int WORDS_AW = 12
)
(
  // Clock and reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  // Sequencer side.
  fsp_flash_if.array fl
);
  logic [15:0] mem [0:(1<<WORDS_AW)-1];
  logic [WORDS_AW-1:0] wa;

  assign wa = fl.op_addr[WORDS_AW:1];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fl.rd_word <= 16'h0000;
    else if (fl.rd_en)
      fl.rd_word <= mem[fl.rd_addr[WORDS_AW:1]];
  end

  // Program only clears bits, as flash does.
  always_ff @(posedge aclk)
  begin
    if (fl.erase_go)
    begin
      for (int i = 0; i < 32; i++)
        mem[{wa[WORDS_AW-1:5], 5'(i)}] <= 16'hffff;
    end
    else if (fl.prog_go)
    begin
      for (int j = 0; j < 4; j++)
        mem[{wa[WORDS_AW-1:2], 2'(j)}] <= mem[{wa[WORDS_AW-1:2], 2'(j)}]
                                          & fl.prog_data[16*j +: 16];
    end
  end
endmodule
`default_nettype wire

//--- fsp_flash_if.sv
/*
  Interface between the sequencer and its flash array model port.
  Assumes a single clock domain; the array answers reads in one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
interface fsp_flash_if;
  logic        rd_en;
  logic [20:0] rd_addr;
  logic [15:0] rd_word;
  logic        erase_go;
  logic        prog_go;
  logic [20:0] op_addr;
  logic [63:0] prog_data;

  modport ctrl (output rd_en, output rd_addr, input rd_word,
                output erase_go, output prog_go, output op_addr, output prog_data);
  modport array (input rd_en, input rd_addr, output rd_word,
                 input erase_go, input prog_go, input op_addr, input prog_data);
endinterface
`default_nettype wire

//--- fsp_pkg.sv
/*
  Package for the program flash self-programming sequencer: register map,
  control field positions, reset values, unlock keys and timing constants.
  Assumes a 200 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
package fsp_pkg;

  // Register byte offsets.
  localparam logic [7:0] FSP_OFF_PTR    = 8'h00;
  localparam logic [7:0] FSP_OFF_LATCH  = 8'h04;
  localparam logic [7:0] FSP_OFF_CTRL   = 8'h08;
  localparam logic [7:0] FSP_OFF_KEY    = 8'h0c;
  localparam logic [7:0] FSP_OFF_TBLOP  = 8'h10;
  localparam logic [7:0] FSP_OFF_STATUS = 8'h14;

  // Control register bit positions.
  localparam int FSP_BIT_RD    = 0;
  localparam int FSP_BIT_WR    = 1;
  localparam int FSP_BIT_WRITE_ALLOW  = 2;
  localparam int FSP_BIT_WRITE_ABORT_FLAG = 3;
  localparam int FSP_BIT_FREE  = 4;
  localparam int FSP_BIT_CONFIG_SPACE_SELECT  = 6;
  localparam int FSP_BIT_PGD   = 7;

  // Table operation command word fields.
  localparam int FSP_OP_WRITE_BIT = 8;
  localparam int FSP_OP_MODE_LSB  = 9;

  localparam logic [1:0] FSP_MODE_PLAIN   = 2'h0;
  localparam logic [1:0] FSP_MODE_POSTINC = 2'h1;
  localparam logic [1:0] FSP_MODE_POSTDEC = 2'h2;
  localparam logic [1:0] FSP_MODE_PREINC  = 2'h3;

  // Unlock key values.
  localparam logic [7:0] FSP_KEY1 = 8'h55;
  localparam logic [7:0] FSP_KEY2 = 8'haa;

  // Reset values.
  localparam logic [7:0]  FSP_CTRL_RST = 8'h00;
  localparam logic [21:0] FSP_PTR_RST  = 22'h000000;

  // Geometry.
  localparam int FSP_PTR_W     = 22;
  localparam int FSP_HOLD_N    = 8;
  localparam int FSP_HOLD_AW   = 3;
  localparam int FSP_ROW_AW    = 6;

  // Long write time: about 2 ms at 200 MHz.
  localparam int FSP_CLK_MHZ    = 200;
  localparam int FSP_LONG_US    = 2000;
  localparam int FSP_LONG_CYC   = FSP_LONG_US * FSP_CLK_MHZ;

  // AXI responses.
  localparam logic [1:0] FSP_RESP_OKAY   = 2'b00;
  localparam logic [1:0] FSP_RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    FSP_ST_IDLE  = 3'b001,
    FSP_ST_READ  = 3'b010,
    FSP_ST_LONG  = 3'b100
  } fsp_state_t;

endpackage

//--- fsp_seq.sv
/*
  Program flash self-programming sequencer with AXI4-Lite register access.
  Assumes the core issues table operations by writing the table op register
  and honours the stall output while a long write runs.
*/
// Contract
// - Each table read moves one byte from flash into the table latch.
// - Pointer bit 0 picks high or low byte of the addressed word.
// - Table read may post-increment, post-decrement or pre-increment the pointer.
// - Erase always clears a whole 64-byte row.
// - Erase row is chosen by pointer bits 20:6.
// - Erase ignores the table latch content.
// - Start needs key 55h then AAh, then write-start set next.
// - Long cycles stall the core until the timer expires.
// - Row erase stalls about 2 ms.
// - Programming works on 8-byte blocks only.
// - Eight byte holding registers are loaded by table writes.
// - Each 8-byte program stalls about 2 ms.
// - Write-start cannot be set while write allow is clear.
// - Hardware clears write-start and read-start on completion.
// - Pointer bits 2:0 pick holding register; bits 20:3 pick program block.
// - Warm reset during a long write sets the write abort flag.
`timescale 1ns/1ps
`default_nettype none
module fsp_seq
  import fsp_pkg::*;
#(
  parameter int LONG_CYC = FSP_LONG_CYC,
  parameter int WORDS_AW = 12
)
(
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Warm reset seen during a long write; keeps the abort flag meaningful.
  input  wire logic        warm_reset,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core stall.
  output logic             core_stall
);
  fsp_flash_if fl ();

  fsp_flash_array #(.WORDS_AW(WORDS_AW)) u_array (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fl      (fl)
  );

  fsp_state_t          state_reg;
  logic [21:0]         ptr_reg;
  logic [7:0]          latch_reg;
  logic [7:0]          ctrl_reg;
  logic [1:0]          key_reg;
  logic                key_ok;
  logic [31:0]         timer_reg;
  logic                rd_lo_reg;
  logic [7:0]          hold_reg [0:FSP_HOLD_N-1];
  logic [7:0]          aw_addr_reg;
  logic [31:0]         w_data_reg;
  logic [3:0]          w_strb_reg;
  logic                aw_have_reg;
  logic                w_have_reg;
  logic                wr_fire;
  logic                wr_map;
  logic                op_fire;
  logic                op_write;
  logic [1:0]          op_mode;
  logic [21:0]         op_ptr;
  logic                start_long;
  logic                long_done;
  logic [63:0]         hold_flat;

  // Write channel capture: address and data in either order.
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid && state_reg == FSP_ST_IDLE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_have_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_have_reg <= 1'b0;
    end
  end

  assign wr_map = aw_addr_reg == FSP_OFF_PTR || aw_addr_reg == FSP_OFF_LATCH
               || aw_addr_reg == FSP_OFF_CTRL || aw_addr_reg == FSP_OFF_KEY
               || aw_addr_reg == FSP_OFF_TBLOP || aw_addr_reg == FSP_OFF_STATUS;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= FSP_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map ? FSP_RESP_OKAY : FSP_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Table operation command decode.
  assign op_fire  = wr_fire && aw_addr_reg == FSP_OFF_TBLOP && w_strb_reg[1];
  assign op_write = w_data_reg[FSP_OP_WRITE_BIT];
  assign op_mode  = w_data_reg[FSP_OP_MODE_LSB +: 2];
  assign op_ptr   = (op_mode == FSP_MODE_PREINC) ? {ptr_reg[21], ptr_reg[20:0] + 21'h1}
                                                  : ptr_reg;

  // Unlock key: two writes in order, then the write-start write must follow.
  assign key_ok = key_reg == 2'd2;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      key_reg <= 2'd0;
    else if (wr_fire)
    begin
      if (aw_addr_reg == FSP_OFF_KEY && w_data_reg[7:0] == FSP_KEY1)
        key_reg <= 2'd1;
      else if (aw_addr_reg == FSP_OFF_KEY && w_data_reg[7:0] == FSP_KEY2 && key_reg == 2'd1)
        key_reg <= 2'd2;
      else
        key_reg <= 2'd0;
    end
  end

  // Long write start: keyed, enabled, program space only.
  assign start_long = wr_fire && aw_addr_reg == FSP_OFF_CTRL && w_strb_reg[0]
                   && w_data_reg[FSP_BIT_WR] && key_ok
                   && ctrl_reg[FSP_BIT_WRITE_ALLOW]
                   && ctrl_reg[FSP_BIT_PGD] && !ctrl_reg[FSP_BIT_CONFIG_SPACE_SELECT];

  assign long_done = state_reg == FSP_ST_LONG && timer_reg == 32'd1;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_reg <= FSP_CTRL_RST;
    else
    begin
      if (wr_fire && aw_addr_reg == FSP_OFF_CTRL && w_strb_reg[0])
      begin
        ctrl_reg[FSP_BIT_PGD]  <= w_data_reg[FSP_BIT_PGD];
        ctrl_reg[FSP_BIT_CONFIG_SPACE_SELECT] <= w_data_reg[FSP_BIT_CONFIG_SPACE_SELECT];
        ctrl_reg[FSP_BIT_FREE] <= w_data_reg[FSP_BIT_FREE];
        ctrl_reg[FSP_BIT_WRITE_ALLOW] <= w_data_reg[FSP_BIT_WRITE_ALLOW];
        if (!w_data_reg[FSP_BIT_WRITE_ABORT_FLAG])
          ctrl_reg[FSP_BIT_WRITE_ABORT_FLAG] <= 1'b0;
      end
      if (start_long)
        ctrl_reg[FSP_BIT_WR] <= 1'b1;
      else if (long_done || (warm_reset && state_reg == FSP_ST_LONG))
      begin
        ctrl_reg[FSP_BIT_WR]   <= 1'b0;
        ctrl_reg[FSP_BIT_FREE] <= 1'b0;
      end
      if (warm_reset && state_reg == FSP_ST_LONG)
        ctrl_reg[FSP_BIT_WRITE_ABORT_FLAG] <= 1'b1;
      ctrl_reg[FSP_BIT_RD] <= 1'b0;
    end
  end

  // Sequencer state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= FSP_ST_IDLE;
      timer_reg <= 32'd0;
    end
    else
    begin
      case (state_reg)
        FSP_ST_IDLE:
        begin
          if (start_long)
          begin
            state_reg <= FSP_ST_LONG;
            timer_reg <= 32'(LONG_CYC);
          end
          else if (op_fire && !op_write)
            state_reg <= FSP_ST_READ;
        end
        FSP_ST_READ:
          state_reg <= FSP_ST_IDLE;
        FSP_ST_LONG:
        begin
          if (warm_reset || long_done)
            state_reg <= FSP_ST_IDLE;
          timer_reg <= timer_reg - 32'd1;
        end
        default:
          state_reg <= FSP_ST_IDLE;
      endcase
    end
  end

  assign core_stall = state_reg == FSP_ST_LONG;

  // Pointer, holding registers and latch.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ptr_reg   <= FSP_PTR_RST;
      rd_lo_reg <= 1'b0;
    end
    else if (op_fire)
    begin
      rd_lo_reg <= op_ptr[0];
      case (op_mode)
        FSP_MODE_POSTINC: ptr_reg <= {ptr_reg[21], ptr_reg[20:0] + 21'h1};
        FSP_MODE_POSTDEC: ptr_reg <= {ptr_reg[21], ptr_reg[20:0] - 21'h1};
        FSP_MODE_PREINC:  ptr_reg <= op_ptr;
        default:          ptr_reg <= ptr_reg;
      endcase
    end
    else if (wr_fire && aw_addr_reg == FSP_OFF_PTR)
      ptr_reg <= w_data_reg[21:0];
  end

  genvar g;
  generate
    for (g = 0; g < FSP_HOLD_N; g++)
    begin : g_hold
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          hold_reg[g] <= 8'hff;
        else if (op_fire && op_write && op_ptr[2:0] == 3'(g))
          hold_reg[g] <= latch_reg;
        else if (long_done && !ctrl_reg[FSP_BIT_FREE])
          hold_reg[g] <= 8'hff;
      end
      assign hold_flat[8*g +: 8] = hold_reg[g];
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      latch_reg <= 8'h00;
    else if (state_reg == FSP_ST_READ)
      latch_reg <= rd_lo_reg ? fl.rd_word[15:8] : fl.rd_word[7:0];
    else if (wr_fire && aw_addr_reg == FSP_OFF_LATCH && w_strb_reg[0])
      latch_reg <= w_data_reg[7:0];
  end

  // Flash array commands; erase ignores the latch and low pointer bits.
  assign fl.rd_en     = op_fire && !op_write;
  assign fl.rd_addr   = op_ptr[20:0];
  assign fl.erase_go  = long_done && ctrl_reg[FSP_BIT_FREE];
  assign fl.prog_go   = long_done && !ctrl_reg[FSP_BIT_FREE];
  assign fl.op_addr   = ctrl_reg[FSP_BIT_FREE] ? {ptr_reg[20:6], 6'h00}
                                               : {ptr_reg[20:3], 3'h0};
  assign fl.prog_data = hold_flat;

  // Read channel.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= FSP_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= FSP_RESP_OKAY;
      case (s_axi_araddr)
        FSP_OFF_PTR:    s_axi_rdata <= {10'h000, ptr_reg};
        FSP_OFF_LATCH:  s_axi_rdata <= {24'h000000, latch_reg};
        FSP_OFF_CTRL:   s_axi_rdata <= {24'h000000, ctrl_reg};
        FSP_OFF_KEY:    s_axi_rdata <= 32'h00000000;
        FSP_OFF_TBLOP:  s_axi_rdata <= 32'h00000000;
        FSP_OFF_STATUS: s_axi_rdata <= {29'h00000000, state_reg};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= FSP_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Checks.
  a_wr_needs_key: assert property (@(posedge aclk) disable iff (!aresetn)
    start_long |-> key_reg == 2'd2 && ctrl_reg[FSP_BIT_WRITE_ALLOW])
    else $error("long write started without key or enable");
  a_stall_on_start: assert property (@(posedge aclk) disable iff (!aresetn)
    start_long |=> core_stall && ctrl_reg[FSP_BIT_WR])
    else $error("stall did not follow start");
  a_wr_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    long_done |=> !ctrl_reg[FSP_BIT_WR] && !core_stall)
    else $error("write-start not cleared at end");
  a_read_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_fire && !op_write && state_reg == FSP_ST_IDLE) |=> ##1
      latch_reg == (rd_lo_reg ? fl.rd_word[15:8] : fl.rd_word[7:0]))
    else $error("table latch not loaded from flash");
  a_ptr_inc: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_fire && op_mode == FSP_MODE_POSTINC) |=>
      ptr_reg[20:0] == $past(ptr_reg[20:0]) + 21'h1)
    else $error("pointer not incremented");
  a_erase_row: assert property (@(posedge aclk) disable iff (!aresetn)
    fl.erase_go |-> fl.op_addr[5:0] == 6'h00)
    else $error("erase address not row aligned");
  a_hold_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_fire && op_write) |=> hold_reg[$past(op_ptr[2:0])] == $past(latch_reg))
    else $error("holding register not loaded");
  a_abort_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (warm_reset && core_stall) |=> ctrl_reg[FSP_BIT_WRITE_ABORT_FLAG] && !core_stall)
    else $error("abort flag not set");
endmodule
`default_nettype wire

//--- tb_fsp_seq.sv
/*
  Testbench for the self-programming sequencer: registers, table ops and long writes.
  Assumes the core model as bus master and a shortened long-write time.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_fsp_seq;
  import fsp_pkg::*;
  localparam int LONG = 20;
  localparam int TMO  = 20000;
  logic        aclk, aresetn, warm_reset, core_stall;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          n_mismatch, checks_done, cyc, stall_run, stall_len;
  logic [31:0] mode_ptr [4] = '{32'h49, 32'h4a, 32'h48, 32'h4a};

  fsp_seq #(.LONG_CYC(LONG), .WORDS_AW(12)) u_fsp_seq (
    .aclk(aclk), .aresetn(aresetn), .warm_reset(warm_reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .core_stall(core_stall));

  fsp_core_model u_fsp_core_model (
    .aclk(aclk), .core_stall(core_stall),
    .m_axi_awaddr(s_axi_awaddr), .m_axi_awvalid(s_axi_awvalid), .m_axi_awready(s_axi_awready),
    .m_axi_wdata(s_axi_wdata), .m_axi_wstrb(s_axi_wstrb), .m_axi_wvalid(s_axi_wvalid),
    .m_axi_wready(s_axi_wready), .m_axi_bresp(s_axi_bresp), .m_axi_bvalid(s_axi_bvalid),
    .m_axi_bready(s_axi_bready), .m_axi_araddr(s_axi_araddr), .m_axi_arvalid(s_axi_arvalid),
    .m_axi_arready(s_axi_arready), .m_axi_rdata(s_axi_rdata), .m_axi_rresp(s_axi_rresp),
    .m_axi_rvalid(s_axi_rvalid), .m_axi_rready(s_axi_rready));

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Length of the last unbroken stall, taken when it falls.
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (core_stall) stall_run <= stall_run + 1;
    else if (stall_run != 0)
    begin
      stall_len <= stall_run;
      stall_run <= 0;
    end
    if (cyc == TMO)
    begin
      n_mismatch++;
      complete_run;
    end
  end

  function automatic logic [7:0] pat(input int k);
    return 8'ha0 ^ k[7:0];
  endfunction

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_fsp_core_model.axi_write(a, d, r);
    check("bresp", {30'h0, r}, {30'h0, FSP_RESP_OKAY});
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    u_fsp_core_model.axi_read(a, d, r);
    check(what, d, exp);
  endtask

  task automatic tbl(input logic w, input logic [1:0] mode);
    wr(FSP_OFF_TBLOP, {21'h0, mode, w, 8'h00});
  endtask

  task automatic byte_chk(input logic [7:0] a, input logic [7:0] exp);
    wr(FSP_OFF_PTR, {24'h0, a});
    tbl(1'b0, FSP_MODE_PLAIN);
    rd_chk("byte", FSP_OFF_LATCH, {24'h0, exp});
  endtask

  task automatic wait_long;
    int n;
    n = 0;
    while (core_stall && n < 1000)
    begin
      @(posedge aclk);
      n++;
    end
    repeat (2) @(posedge aclk);
  endtask

  task automatic long_op(input logic [7:0] ctrl);
    logic [31:0] d;
    logic [1:0] r;
    u_fsp_core_model.unlock_start(ctrl);
    wait_long;
    check("stall length", stall_len, LONG);
    u_fsp_core_model.axi_read(FSP_OFF_CTRL, d, r);
    check("start bit", d & 32'h2, 32'h0);
  endtask

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    aresetn = 1'b0;
    warm_reset = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    cyc = 0;
    stall_run = 0;
    stall_len = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("ptr", FSP_OFF_PTR, 32'h0);
    rd_chk("latch", FSP_OFF_LATCH, 32'h0);
    rd_chk("ctrl", FSP_OFF_CTRL, 32'h0);
    rd_chk("key", FSP_OFF_KEY, 32'h0);
    rd_chk("status", FSP_OFF_STATUS, 32'h1);
    u_fsp_core_model.axi_read(8'h18, d, r);
    check("unmapped", {30'h0, r}, {30'h0, FSP_RESP_SLVERR});
    u_fsp_core_model.axi_write(8'h18, 32'h0, r);
    check("unmapped wr", {30'h0, r}, {30'h0, FSP_RESP_SLVERR});
    $display("test reset done");
    u_fsp_core_model.unlock_start(8'h80);
    rd_chk("status no allow", FSP_OFF_STATUS, 32'h1);
    rd_chk("ctrl no allow", FSP_OFF_CTRL, 32'h80);
    wr(FSP_OFF_CTRL, 32'h84);
    wr(FSP_OFF_KEY, 32'h55);
    wr(FSP_OFF_PTR, 32'h0);
    wr(FSP_OFF_KEY, 32'haa);
    wr(FSP_OFF_CTRL, 32'h86);
    rd_chk("status broken key", FSP_OFF_STATUS, 32'h1);
    $display("test refusal done");
    wr(FSP_OFF_PTR, 32'h7b);
    wr(FSP_OFF_LATCH, 32'h0);
    long_op(8'h94);
    byte_chk(8'h40, 8'hff);
    byte_chk(8'h7f, 8'hff);
    $display("test erase done");
    for (int b = 0; b < 8; b++)
    begin
      wr(FSP_OFF_PTR, 32'(32'h40 + 8 * b));
      for (int i = 0; i < 8; i++)
      begin
        wr(FSP_OFF_LATCH, {24'h0, pat(8 * b + i)});
        tbl(1'b1, FSP_MODE_POSTINC);
      end
      if (b == 0) byte_chk(8'h40, 8'hff);
      wr(FSP_OFF_PTR, 32'(32'h47 + 8 * b));
      long_op(8'h84);
    end
    wr(FSP_OFF_PTR, 32'h40);
    for (int k = 0; k < 64; k++)
    begin
      tbl(1'b0, FSP_MODE_POSTINC);
      rd_chk("row byte", FSP_OFF_LATCH, {24'h0, pat(k)});
    end
    rd_chk("ptr after row", FSP_OFF_PTR, 32'h80);
    $display("test program done");
    for (int m = 0; m < 4; m++)
    begin
      wr(FSP_OFF_PTR, 32'h49);
      tbl(1'b0, 2'(m));
      rd_chk("mode latch", FSP_OFF_LATCH, {24'h0, pat(m == 3 ? 10 : 9)});
      rd_chk("mode ptr", FSP_OFF_PTR, mode_ptr[m]);
    end
    $display("test modes done");
    wr(FSP_OFF_PTR, 32'h40);
    u_fsp_core_model.unlock_start(8'h94);
    rd_chk("status long", FSP_OFF_STATUS, 32'h4);
    warm_reset <= 1'b1;
    repeat (2) @(posedge aclk);
    warm_reset <= 1'b0;
    wait_long;
    u_fsp_core_model.axi_read(FSP_OFF_CTRL, d, r);
    check("abort flag", d & 32'h8, 32'h8);
    check("abort start bit", d & 32'h2, 32'h0);
    wr(FSP_OFF_CTRL, 32'h80);
    rd_chk("abort cleared", FSP_OFF_CTRL, 32'h80);
    $display("test abort done");
    complete_run;
  end
endmodule
`default_nettype wire
